//--- verilog/uartc_pkg.sv
// Constants and types for the asynchronous serial transmitter and receiver core
// Functional notes
// - Load strobe captures parallel character into holding buffer
// - Short characters send only low-order bits
// - Load strobe rise drives holding-empty low
// - Idle shifter takes character within one bit-clock
// - Transmit bit lasts sixteen bit-clock periods
// - Load during shifting only fills holding buffer
// - Waiting character moves automatically, starts one clock later
// - Add start, parity, stop framing on serial output
// - Receiver shifts with sixteen-times bit-rate clock
// - Clear input drops data-ready flag
// - Copy received character during first stop bit
// - Received short characters zero-filled in upper bits
// - Overrun set when data-ready still pending at copy
// - Data-ready and framing flag one clock after copy
// - Framing error when stop bit is low
// - Parity error when received parity mismatches
`default_nettype none
package uartc_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL  = 8'h00;
  localparam logic [7:0] OFF_DIV   = 8'h04;
  localparam logic [7:0] OFF_TXD   = 8'h08;
  localparam logic [7:0] OFF_RXD   = 8'h0C;
  localparam logic [7:0] OFF_STAT  = 8'h10;
  localparam logic [7:0] OFF_ISTAT = 8'h14;
  localparam logic [7:0] OFF_IMASK = 8'h18;
  // Control fields
  localparam int CTL_W   = 5;
  localparam int CTL_LEN = 0;
  localparam int CTL_PI  = 2;
  localparam int CTL_EPE = 3;
  localparam int CTL_SBS = 4;
  localparam logic [4:0]  CTRL_RST = 5'h07;
  localparam logic [31:0] DIV_RST  = 32'h000C_000C;
  localparam int DIV_TX_LSB = 0;
  localparam int DIV_RX_LSB = 16;
  // Status fields
  localparam int ST_THE = 0;
  localparam int ST_TSE = 1;
  localparam int ST_DR  = 2;
  localparam int ST_OE  = 3;
  localparam int ST_FE  = 4;
  localparam int ST_PE  = 5;
  // Interrupt fields
  localparam int IRQ_W  = 5;
  localparam int IRQ_RX = 0;
  localparam int IRQ_OE = 1;
  localparam int IRQ_FE = 2;
  localparam int IRQ_PE = 3;
  localparam int IRQ_TX = 4;
  // Character and frame
  localparam int DATA_W  = 8;
  localparam int FRAME_W = 12;
  localparam logic [3:0] MIN_LEN  = 4'h5;
  localparam logic [3:0] SUB_LAST = 4'hF;
  localparam logic [3:0] SUB_MID  = 4'h7;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} uartc_rx_state_type;
endpackage
`default_nettype wire

//--- verilog/uartc_core.sv
// Asynchronous serial transmitter and receiver core with AXI4-Lite registers
`timescale 1ns/100ps
`default_nettype none
module uartc_core (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             tx_serial_out,
  input  wire logic        rx_serial_in,
  output logic             irq
);
  logic                         aw_got_ff, w_got_ff, bvalid_ff, rvalid_ff, irq_ff;
  logic [7:0]                   aw_addr_ff;
  logic [31:0]                  wdata_ff, rdata_ff, div_ff, wmask;
  logic [3:0]                   wstrb_ff;
  logic [1:0]                   bresp_ff, rresp_ff;
  logic                         wr_do, rd_do, wr_map, rd_map;
  logic [uartc_pkg::CTL_W-1:0]  ctrl_ff;
  logic [uartc_pkg::IRQ_W-1:0]  istat_ff, imask_ff, irq_ev;
  logic [15:0]                  tx_div_cnt_ff, rx_div_cnt_ff;
  logic                         tx_bit_clock, rx_bit_clock;
  logic [3:0]                   data_len;
  logic [uartc_pkg::DATA_W-1:0] dmask;
  logic                         par_inh, even_par;
  logic                         tx_holding_load, tx_xfer, tx_par;
  logic [uartc_pkg::DATA_W-1:0] tx_holding_ff;
  logic                         tx_full_ff, tx_busy_ff;
  logic [uartc_pkg::FRAME_W-1:0] tx_sr_ff, tx_frame;
  logic [3:0]                   tx_sub_ff, tx_left_ff, tx_nbits;
  logic                         rx_s1_ff, rx_s2_ff;
  uartc_pkg::uartc_rx_state_type rx_state_ff;
  logic [3:0]                   rx_sub_ff, rx_idx_ff;
  logic [uartc_pkg::DATA_W-1:0] rx_sr_ff, rx_holding_buffer_ff;
  logic                         rx_par_ff, rx_stop_ff, rx_pend_ff, rx_xfer, dr_set, pe_calc;
  logic                         data_ready_flag_ff, overrun_ff;
  logic                         framing_error_flag_ff, parity_error_flag_ff;
  logic                         received_char_clear;

  // Bus handshakes: one write and one read in flight
  assign s_axi_awready = !aw_got_ff && !bvalid_ff;
  assign s_axi_wready  = !w_got_ff && !bvalid_ff;
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rresp   = rresp_ff;
  assign s_axi_rdata   = rdata_ff;
  assign irq           = irq_ff;
  assign wr_do = aw_got_ff && w_got_ff && !bvalid_ff;
  assign rd_do = s_axi_arvalid && !rvalid_ff;
  assign wmask = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}}, {8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
  assign wr_map = aw_addr_ff inside {uartc_pkg::OFF_CTRL, uartc_pkg::OFF_DIV,
                  uartc_pkg::OFF_TXD, uartc_pkg::OFF_ISTAT, uartc_pkg::OFF_IMASK};
  assign rd_map = s_axi_araddr[7:0] inside {uartc_pkg::OFF_CTRL, uartc_pkg::OFF_DIV,
                  uartc_pkg::OFF_TXD, uartc_pkg::OFF_RXD, uartc_pkg::OFF_STAT,
                  uartc_pkg::OFF_ISTAT, uartc_pkg::OFF_IMASK} && s_axi_araddr[31:8] == 24'h00_0000;

  // Address and data may arrive in either order; each is held until both are in
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_ff  <= 1'b0;
      w_got_ff   <= 1'b0;
      aw_addr_ff <= 8'h00;
      wdata_ff   <= 32'h0000_0000;
      wstrb_ff   <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_ff  <= 1'b1;
        aw_addr_ff <= (s_axi_awaddr[31:8] == 24'h00_0000) ? s_axi_awaddr[7:0] : 8'hFF;
      end else if (wr_do) begin
        aw_got_ff <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end else if (wr_do) begin
        w_got_ff <= 1'b0;
      end
    end
  end

  // Write response; unmapped addresses answer SLVERR
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= uartc_pkg::RESP_OKAY;
    end else if (wr_do) begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= wr_map ? uartc_pkg::RESP_OKAY : uartc_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // Read data captured at the address handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rresp_ff  <= uartc_pkg::RESP_OKAY;
      rdata_ff  <= 32'h0000_0000;
    end else if (rd_do) begin
      rvalid_ff <= 1'b1;
      rresp_ff  <= rd_map ? uartc_pkg::RESP_OKAY : uartc_pkg::RESP_SLVERR;
      rdata_ff  <= 32'h0000_0000;
      unique case (s_axi_araddr[7:0])
        uartc_pkg::OFF_CTRL:  rdata_ff[uartc_pkg::CTL_W-1:0] <= ctrl_ff;
        uartc_pkg::OFF_DIV:   rdata_ff <= div_ff;
        uartc_pkg::OFF_TXD:   rdata_ff[uartc_pkg::DATA_W-1:0] <= tx_holding_ff;
        uartc_pkg::OFF_RXD:   rdata_ff[uartc_pkg::DATA_W-1:0] <= rx_holding_buffer_ff;
        uartc_pkg::OFF_STAT: begin
          rdata_ff[uartc_pkg::ST_THE] <= !tx_full_ff;
          rdata_ff[uartc_pkg::ST_TSE] <= !tx_busy_ff;
          rdata_ff[uartc_pkg::ST_DR]  <= data_ready_flag_ff;
          rdata_ff[uartc_pkg::ST_OE]  <= overrun_ff;
          rdata_ff[uartc_pkg::ST_FE]  <= framing_error_flag_ff;
          rdata_ff[uartc_pkg::ST_PE]  <= parity_error_flag_ff;
        end
        uartc_pkg::OFF_ISTAT: rdata_ff[uartc_pkg::IRQ_W-1:0] <= istat_ff;
        uartc_pkg::OFF_IMASK: rdata_ff[uartc_pkg::IRQ_W-1:0] <= imask_ff;
        default:              rdata_ff <= 32'h0000_0000;
      endcase
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  // Reading the receive buffer acts as the clear strobe
  assign received_char_clear = rd_do && s_axi_araddr == {24'h00_0000, uartc_pkg::OFF_RXD};
  assign tx_holding_load = wr_do && aw_addr_ff == uartc_pkg::OFF_TXD && wstrb_ff[0];

  // Configuration registers, byte-lane merged
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ff  <= uartc_pkg::CTRL_RST;
      div_ff   <= uartc_pkg::DIV_RST;
      imask_ff <= '0;
    end else if (wr_do) begin
      if (aw_addr_ff == uartc_pkg::OFF_CTRL)
        ctrl_ff <= (ctrl_ff & ~wmask[uartc_pkg::CTL_W-1:0]) | (wdata_ff[uartc_pkg::CTL_W-1:0] & wmask[uartc_pkg::CTL_W-1:0]);
      if (aw_addr_ff == uartc_pkg::OFF_DIV)
        div_ff <= (div_ff & ~wmask) | (wdata_ff & wmask);
      if (aw_addr_ff == uartc_pkg::OFF_IMASK)
        imask_ff <= (imask_ff & ~wmask[uartc_pkg::IRQ_W-1:0]) | (wdata_ff[uartc_pkg::IRQ_W-1:0] & wmask[uartc_pkg::IRQ_W-1:0]);
    end
  end

  // Sticky events, write one to clear; a new event wins over the clear
  assign irq_ev[uartc_pkg::IRQ_RX] = dr_set;
  assign irq_ev[uartc_pkg::IRQ_OE] = rx_xfer && data_ready_flag_ff;
  assign irq_ev[uartc_pkg::IRQ_FE] = dr_set && !rx_stop_ff;
  assign irq_ev[uartc_pkg::IRQ_PE] = rx_xfer && pe_calc;
  assign irq_ev[uartc_pkg::IRQ_TX] = tx_xfer;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      istat_ff <= '0;
      irq_ff   <= 1'b0;
    end else begin
      if (wr_do && aw_addr_ff == uartc_pkg::OFF_ISTAT)
        istat_ff <= (istat_ff & ~(wdata_ff[uartc_pkg::IRQ_W-1:0] & wmask[uartc_pkg::IRQ_W-1:0])) | irq_ev;
      else
        istat_ff <= istat_ff | irq_ev;
      irq_ff <= |(istat_ff & imask_ff);
    end
  end

  // Sixteen-times bit-rate enables, one per direction
  assign tx_bit_clock = tx_div_cnt_ff >= div_ff[uartc_pkg::DIV_TX_LSB +: 16];
  assign rx_bit_clock = rx_div_cnt_ff >= div_ff[uartc_pkg::DIV_RX_LSB +: 16];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_div_cnt_ff <= 16'h0000;
      rx_div_cnt_ff <= 16'h0000;
    end else begin
      tx_div_cnt_ff <= tx_bit_clock ? 16'h0000 : tx_div_cnt_ff + 16'h0001;
      rx_div_cnt_ff <= rx_bit_clock ? 16'h0000 : rx_div_cnt_ff + 16'h0001;
    end
  end

  // Character format decode shared by both directions
  assign data_len = {2'b00, ctrl_ff[uartc_pkg::CTL_LEN +: 2]} + uartc_pkg::MIN_LEN;
  assign par_inh  = ctrl_ff[uartc_pkg::CTL_PI];
  assign even_par = ctrl_ff[uartc_pkg::CTL_EPE];
  assign dmask    = 8'hFF >> (4'h8 - data_len);

  // Holding buffer; a load keeps it full through a same-cycle transfer of the old character to the shifter
  assign tx_xfer = tx_bit_clock && !tx_busy_ff && tx_full_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_holding_ff <= 8'h00;
      tx_full_ff    <= 1'b0;
    end else if (tx_holding_load) begin
      tx_holding_ff <= wdata_ff[uartc_pkg::DATA_W-1:0] & dmask;
      tx_full_ff    <= 1'b1;
    end else if (tx_xfer) begin
      tx_full_ff <= 1'b0;
    end
  end

  // Frame builder: start, data low bit first, optional parity, stops
  assign tx_par = ^tx_holding_ff ^ ~even_par;
  always_comb begin
    tx_frame    = '1;
    tx_frame[0] = 1'b0;
    for (int i = 0; i < uartc_pkg::DATA_W; i++) begin
      if (i < int'(data_len))
        tx_frame[1 + i] = tx_holding_ff[i];
    end
    if (!par_inh)
      tx_frame[4'h1 + data_len] = tx_par;
    tx_nbits = 4'h1 + data_len + {3'b000, !par_inh} + (ctrl_ff[uartc_pkg::CTL_SBS] ? 4'h2 : 4'h1);
  end

  // Shifter: each bit held for sixteen enables; shifts in ones so the line idles high
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_sr_ff   <= '1;
      tx_busy_ff <= 1'b0;
      tx_sub_ff  <= 4'h0;
      tx_left_ff <= 4'h0;
    end else if (tx_xfer) begin
      tx_sr_ff   <= tx_frame;
      tx_left_ff <= tx_nbits;
      tx_sub_ff  <= 4'h0;
      tx_busy_ff <= 1'b1;
    end else if (tx_bit_clock && tx_busy_ff) begin
      tx_sub_ff <= tx_sub_ff + 4'h1;
      if (tx_sub_ff == uartc_pkg::SUB_LAST) begin
        tx_sr_ff   <= {1'b1, tx_sr_ff[uartc_pkg::FRAME_W-1:1]};
        tx_left_ff <= tx_left_ff - 4'h1;
        if (tx_left_ff == 4'h1)
          tx_busy_ff <= 1'b0;
      end
    end
  end
  assign tx_serial_out = tx_sr_ff[0];

  // Two-flop synchroniser on the receive pin
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_s1_ff <= 1'b1;
      rx_s2_ff <= 1'b1;
    end else begin
      rx_s1_ff <= rx_serial_in;
      rx_s2_ff <= rx_s1_ff;
    end
  end

  // Receive sequencer; a start that is high at its midpoint is treated as noise
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_state_ff <= uartc_pkg::RX_IDLE;
      rx_sub_ff   <= 4'h0;
      rx_idx_ff   <= 4'h0;
      rx_sr_ff    <= 8'h00;
      rx_par_ff   <= 1'b0;
      rx_stop_ff  <= 1'b1;
    end else if (rx_bit_clock) begin
      rx_sub_ff <= rx_sub_ff + 4'h1;
      unique case (rx_state_ff)
        uartc_pkg::RX_IDLE: begin
          rx_sub_ff <= 4'h0;
          if (!rx_s2_ff)
            rx_state_ff <= uartc_pkg::RX_START;
        end
        uartc_pkg::RX_START: begin
          if (rx_sub_ff == uartc_pkg::SUB_MID) begin
            rx_sub_ff   <= 4'h0;
            rx_idx_ff   <= 4'h0;
            rx_sr_ff    <= 8'h00;
            rx_state_ff <= rx_s2_ff ? uartc_pkg::RX_IDLE : uartc_pkg::RX_DATA;
          end
        end
        uartc_pkg::RX_DATA: begin
          if (rx_sub_ff == uartc_pkg::SUB_LAST) begin
            rx_sr_ff[rx_idx_ff[2:0]] <= rx_s2_ff;
            rx_idx_ff <= rx_idx_ff + 4'h1;
            if (rx_idx_ff == data_len - 4'h1)
              rx_state_ff <= par_inh ? uartc_pkg::RX_STOP : uartc_pkg::RX_PAR;
          end
        end
        uartc_pkg::RX_PAR: begin
          if (rx_sub_ff == uartc_pkg::SUB_LAST) begin
            rx_par_ff   <= rx_s2_ff;
            rx_state_ff <= uartc_pkg::RX_STOP;
          end
        end
        uartc_pkg::RX_STOP: begin
          if (rx_sub_ff == uartc_pkg::SUB_LAST) begin
            rx_stop_ff  <= rx_s2_ff;
            rx_state_ff <= uartc_pkg::RX_IDLE;
          end
        end
      endcase
    end
  end

  // Copy at mid first stop bit; data-ready and framing flags follow one receive enable later
  assign rx_xfer = rx_bit_clock && rx_state_ff == uartc_pkg::RX_STOP && rx_sub_ff == uartc_pkg::SUB_LAST;
  assign pe_calc = !par_inh && (rx_par_ff != (^rx_sr_ff ^ ~even_par));
  assign dr_set  = rx_bit_clock && rx_pend_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_holding_buffer_ff  <= 8'h00;
      overrun_ff            <= 1'b0;
      parity_error_flag_ff  <= 1'b0;
      framing_error_flag_ff <= 1'b0;
      rx_pend_ff            <= 1'b0;
    end else if (rx_xfer) begin
      rx_holding_buffer_ff <= rx_sr_ff & dmask;
      overrun_ff           <= data_ready_flag_ff;
      parity_error_flag_ff <= pe_calc;
      rx_pend_ff           <= 1'b1;
    end else if (dr_set) begin
      rx_pend_ff            <= 1'b0;
      framing_error_flag_ff <= !rx_stop_ff;
    end
  end

  // Data-ready: the set wins over a same-cycle clear
  always_ff @(posedge aclk) begin
    if (!aresetn)
      data_ready_flag_ff <= 1'b0;
    else if (dr_set)
      data_ready_flag_ff <= 1'b1;
    else if (received_char_clear)
      data_ready_flag_ff <= 1'b0;
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  load_fills_buf_a: assert property (tx_holding_load |=> tx_full_ff && tx_holding_ff == ($past(wdata_ff[7:0]) & $past(dmask)))
    else $error("load did not fill holding buffer");
  idle_xfer_a: assert property (tx_bit_clock && !tx_busy_ff && tx_full_ff && !tx_holding_load |=> tx_busy_ff && !tx_full_ff && !tx_serial_out)
    else $error("idle shifter did not take character");
  busy_holds_a: assert property (tx_busy_ff && tx_full_ff |=> tx_full_ff)
    else $error("holding buffer drained while shifting");
  bit_pace_a: assert property ($changed(tx_serial_out) |-> $past(tx_bit_clock) && ($past(tx_sub_ff) == 4'hF || $past(tx_xfer)))
    else $error("serial output changed off a bit boundary");
  idle_high_a: assert property (!tx_busy_ff |-> tx_serial_out)
    else $error("transmit line not high while idle");
  clear_drops_a: assert property (received_char_clear && !dr_set |=> !data_ready_flag_ff)
    else $error("data ready not cleared");
  overrun_set_a: assert property (rx_xfer |=> overrun_ff == $past(data_ready_flag_ff))
    else $error("overrun flag wrong after copy");
  upper_zero_a: assert property (rx_xfer |=> (rx_holding_buffer_ff & ~$past(dmask)) == 8'h00)
    else $error("unused received bits not zero");
  frame_flag_a: assert property (dr_set |=> data_ready_flag_ff && framing_error_flag_ff == !$past(rx_stop_ff))
    else $error("framing flag wrong");
  parity_flag_a: assert property (rx_xfer |=> parity_error_flag_ff == $past(pe_calc))
    else $error("parity flag wrong");
endmodule
`default_nettype wire

//--- dv/uartc_remote.sv
// Remote serial partner: frame sender and frame checker on the line
`timescale 1ns/100ps
`default_nettype none
module uartc_remote (
  input  wire logic       aclk,
  input  wire logic [4:0] fmt_ctrl,
  input  wire logic       line_in,
  output logic            line_out
);
  logic [9:0] got_q[$];
  logic [7:0] d;
  logic       p;
  logic       ok;
  int         n;
  // Line rests high outside frames
  initial line_out = 1'b1;
  // One bit is sixteen clocks with both dividers at zero
  task automatic put_bit(input logic b);
    line_out <= b;
    repeat (16) @(posedge aclk);
  endtask
  // Faults are sent only when a test asks for them
  task automatic send_char(input logic [7:0] c, input logic bad_stop, input logic bad_par);
    int         i;
    logic [7:0] m;
    m = c & (8'hFF >> (3 - fmt_ctrl[1:0]));
    @(posedge aclk);
    put_bit(1'b0);
    for (i = 0; i < 5 + fmt_ctrl[1:0]; i++) put_bit(m[i]);
    if (!fmt_ctrl[uartc_pkg::CTL_PI]) put_bit(^m ^ !fmt_ctrl[uartc_pkg::CTL_EPE] ^ bad_par);
    put_bit(!bad_stop);
    if (fmt_ctrl[uartc_pkg::CTL_SBS]) put_bit(!bad_stop);
    put_bit(1'b1);
  endtask
  // Sample mid-bit; a wrong bit time drifts off the centre within a frame
  initial forever begin
    @(negedge line_in);
    repeat (8) @(posedge aclk);
    ok = !line_in;
    d = 8'h00;
    for (n = 0; n < 5 + fmt_ctrl[1:0]; n++) begin
      repeat (16) @(posedge aclk);
      d[n] = line_in;
    end
    p = 1'b1;
    if (!fmt_ctrl[uartc_pkg::CTL_PI]) begin
      repeat (16) @(posedge aclk);
      p = (^d ^ line_in) != fmt_ctrl[uartc_pkg::CTL_EPE];
    end
    repeat (16) @(posedge aclk);
    ok = ok & line_in;
    if (fmt_ctrl[uartc_pkg::CTL_SBS]) begin
      repeat (16) @(posedge aclk);
      ok = ok & line_in;
    end
    got_q.push_back({p, ok, d});
  end
endmodule
`default_nettype wire

//--- dv/test_uartc_core.sv
// Self-checking bench for the serial core: registers, both directions, flags, interrupt
`timescale 1ns/100ps
`default_nettype none
module test_uartc_core;
  localparam logic [20:0] ROWS [6] = '{21'h00_FF1F, 21'h19_AA2A, 21'h06_C343,
                                       21'h13_5A5A, 21'h0B_8181, 21'h14_E606};
  logic        aclk;
  logic        aresetn;
  logic [31:0] awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [31:0] araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  logic        tx_line;
  logic        rx_line;
  logic        irq;
  logic [4:0]  fmt_ctrl;
  logic [31:0] rd;
  logic [1:0]  rsp;
  int          n_errors;
  int          n_checks;
  int          cyc;
  int          i;
  uartc_core dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .tx_serial_out(tx_line), .rx_serial_in(rx_line), .irq(irq)
  );
  uartc_remote remote (.aclk(aclk), .fmt_ctrl(fmt_ctrl), .line_in(tx_line), .line_out(rx_line));
  // 25 MHz clock
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  // Hang guard, well above the few thousand cycles the tests need
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      $display("CHECK FAILED %0t timeout", $time);
      end_sim;
    end
  end
  task automatic end_sim;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string s);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, s, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp, input string s);
    chk_val({31'h0000_0000, got}, {31'h0000_0000, exp}, s);
  endtask
  // Handshakes are judged at the falling edge, where all signals are settled
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_t;
    logic w_t;
    logic b_t;
    @(posedge aclk);
    awaddr <= {24'h00_0000, a};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    b_t = 1'b0;
    // No cycle budget of its own: only the hang guard ends a stalled wait
    while (!b_t) begin
      @(negedge aclk);
      aw_t = awvalid & awready;
      w_t = wvalid & wready;
      b_t = bvalid & bready;
      r = bresp;
      @(posedge aclk);
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
      if (b_t) bready <= 1'b0;
    end
    chk_bit(b_t, 1'b1, "write answer");
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_t;
    logic r_t;
    @(posedge aclk);
    araddr <= {24'h00_0000, a};
    arvalid <= 1'b1;
    rready <= 1'b1;
    r_t = 1'b0;
    while (!r_t) begin
      @(negedge aclk);
      ar_t = arvalid & arready;
      r_t = rvalid & rready;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ar_t) arvalid <= 1'b0;
      if (r_t) rready <= 1'b0;
    end
    chk_bit(r_t, 1'b1, "read answer");
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    axi_wr(a, d, rsp);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                        input string s);
    axi_rd(a, rd, rsp);
    chk_val(rd & m, e, s);
  endtask
  task automatic wait_tx(input int k);
    int n;
    for (n = 0; n < 3000 && remote.got_q.size() < k; n++) @(posedge aclk);
    chk_bit(remote.got_q.size() >= k, 1'b1, "frame seen");
  endtask
  task automatic chk_irq(input logic e);
    @(negedge aclk);
    chk_bit(irq, e, "irq level");
  endtask
  initial begin
    {aresetn, awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
    {n_errors, n_checks} = '0;
    fmt_ctrl = 5'h07;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    // Reset values, then the unmapped word
    chk_irq(1'b0);
    chk_bit(tx_line, 1'b1, "idle line");
    rd_chk(uartc_pkg::OFF_CTRL, 32'hFFFF_FFFF, 32'h0000_0007, "ctrl reset");
    rd_chk(uartc_pkg::OFF_DIV, 32'hFFFF_FFFF, 32'h000C_000C, "div reset");
    rd_chk(uartc_pkg::OFF_IMASK, 32'hFFFF_FFFF, 32'h0000_0000, "mask reset");
    rd_chk(uartc_pkg::OFF_ISTAT, 32'hFFFF_FFFF, 32'h0000_0000, "events reset");
    rd_chk(uartc_pkg::OFF_STAT, 32'h0000_003F, 32'h0000_0003, "status reset");
    rd_chk(8'h1C, 32'hFFFF_FFFF, 32'h0000_0000, "unmapped data");
    chk_val({30'h0000_0000, rsp}, 32'h0000_0002, "unmapped read");
    axi_wr(8'h1C, 32'h0000_0001, rsp);
    chk_val({30'h0000_0000, rsp}, 32'h0000_0002, "unmapped write");
    wr(uartc_pkg::OFF_DIV, 32'h0000_0000);
    $display("test reset done");
    // Every length, parity mode and stop count, both directions
    for (i = 0; i < 6; i++) begin
      fmt_ctrl <= ROWS[i][20:16];
      wr(uartc_pkg::OFF_CTRL, {27'h000_0000, ROWS[i][20:16]});
      wr(uartc_pkg::OFF_TXD, {24'h00_0000, ROWS[i][15:8]});
      wait_tx(1);
      chk_val(remote.got_q.pop_front(), {22'h00_0003, ROWS[i][7:0]}, "tx frame");
      remote.send_char(ROWS[i][15:8], 1'b0, 1'b0);
      rd_chk(uartc_pkg::OFF_STAT, 32'h0000_003C, 32'h0000_0004, "ready set");
      rd_chk(uartc_pkg::OFF_RXD, 32'hFFFF_FFFF, {24'h00_0000, ROWS[i][7:0]}, "rx");
      rd_chk(uartc_pkg::OFF_STAT, 32'h0000_003C, 32'h0000_0000, "ready clear");
      $display("test format row %0d done", i);
    end
    // Second load waits behind the character on the line
    fmt_ctrl <= 5'h07;
    wr(uartc_pkg::OFF_CTRL, 32'h0000_0007);
    wr(uartc_pkg::OFF_TXD, 32'h0000_0011);
    wr(uartc_pkg::OFF_TXD, 32'h0000_0022);
    rd_chk(uartc_pkg::OFF_STAT, 32'h0000_0003, 32'h0000_0000, "both full");
    wait_tx(2);
    chk_val(remote.got_q.pop_front(), 32'h0000_0311, "first char");
    chk_val(remote.got_q.pop_front(), 32'h0000_0322, "second char");
    repeat (16) @(posedge aclk); // Stop bit still shifting when the partner samples its middle
    rd_chk(uartc_pkg::OFF_STAT, 32'h0000_0003, 32'h0000_0003, "tx idle");
    $display("test back to back done");
    // Overrun, interrupt raise, mask and clear
    wr(uartc_pkg::OFF_ISTAT, 32'h0000_001F);
    wr(uartc_pkg::OFF_IMASK, 32'h0000_0003);
    remote.send_char(8'h33, 1'b0, 1'b0);
    chk_irq(1'b1);
    remote.send_char(8'h44, 1'b0, 1'b0);
    rd_chk(uartc_pkg::OFF_STAT, 32'h0000_003C, 32'h0000_000C, "overrun");
    rd_chk(uartc_pkg::OFF_RXD, 32'hFFFF_FFFF, 32'h0000_0044, "newest char");
    rd_chk(uartc_pkg::OFF_ISTAT, 32'h0000_0003, 32'h0000_0003, "events held");
    wr(uartc_pkg::OFF_IMASK, 32'h0000_0000);
    chk_irq(1'b0);
    wr(uartc_pkg::OFF_IMASK, 32'h0000_0003);
    chk_irq(1'b1);
    wr(uartc_pkg::OFF_ISTAT, 32'h0000_001F);
    chk_irq(1'b0);
    $display("test overrun irq done");
    // Low stop bit, then a wrong parity bit
    remote.send_char(8'h55, 1'b1, 1'b0);
    rd_chk(uartc_pkg::OFF_STAT, 32'h0000_0010, 32'h0000_0010, "framing");
    rd_chk(uartc_pkg::OFF_RXD, 32'hFFFF_FFFF, 32'h0000_0055, "framed char");
    fmt_ctrl <= 5'h03;
    wr(uartc_pkg::OFF_CTRL, 32'h0000_0003);
    remote.send_char(8'h66, 1'b0, 1'b1);
    rd_chk(uartc_pkg::OFF_STAT, 32'h0000_0020, 32'h0000_0020, "parity");
    rd_chk(uartc_pkg::OFF_RXD, 32'hFFFF_FFFF, 32'h0000_0066, "parity char");
    $display("test line errors done");
    end_sim;
  end
endmodule
`default_nettype wire
